// [src/cb_writer.sv]
// Purpose: host sequencer writing a checkerboard into the byte-wide array
// Assumes: inputs synchronous to sys_clk; write_strobe is a one-cycle pulse, load_strobe stays high 16 cycles per row
// Notes: margin pins are logic-level requests to the analog drivers
`include "cb_writer_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module cb_writer (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    // user control
    input wire logic start,
    input wire logic invert,
    input wire logic margin_start,
    input wire logic margin_stop,
    output logic busy,
    output logic done,
    // device side
    output logic [12:0] addr,
    output logic [7:0] data_out,
    output logic load_strobe,
    output logic write_strobe,
    input wire logic write_busy,
    output logic chip_select,
    output logic margin_voltage_pin,
    output logic margin_enable_pin
);
    cb_writer_pkg::wr_state_t state_reg;
    logic [12:0] addr_reg;
    logic [7:0] data_reg;
    logic inv_reg;
    logic [`CB_CNT_W-1:0] cnt_reg;
    logic [3:0] col;
    logic [6:0] row;
    logic last_col;
    logic last_row;

    assign col = addr_reg[`CB_ROW_LSB-1:`CB_COL_LSB];
    assign row = addr_reg[`CB_BANK_LSB-1:`CB_ROW_LSB];
    assign last_col = (col == `CB_LAST_COL);
    assign last_row = (row == `CB_LAST_ROW);

    // sequencing state
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            state_reg <= cb_writer_pkg::ST_IDLE;
        end
        else
        begin
            case (state_reg)
                cb_writer_pkg::ST_IDLE:
                begin
                    if (start)
                        state_reg <= cb_writer_pkg::ST_LOAD;
                    else if (margin_start)
                        state_reg <= cb_writer_pkg::ST_MSETUP;
                end
                cb_writer_pkg::ST_LOAD:
                begin
                    if (last_col)
                        state_reg <= cb_writer_pkg::ST_WRITE;
                end
                cb_writer_pkg::ST_WRITE:
                    state_reg <= cb_writer_pkg::ST_WAIT;
                cb_writer_pkg::ST_WAIT:
                begin
                    // device busy may rise a cycle late, so hold one cycle first
                    if (!write_busy && cnt_reg != '0)
                    begin
                        if (addr_reg == `CB_LAST_ADDR)
                            state_reg <= cb_writer_pkg::ST_IDLE;
                        else
                            state_reg <= cb_writer_pkg::ST_LOAD;
                    end
                end
                cb_writer_pkg::ST_MSETUP:
                begin
                    if (cnt_reg == `CB_CNT_W'(`CB_MARGIN_SETUP_CYC - 1))
                        state_reg <= cb_writer_pkg::ST_MREAD;
                end
                cb_writer_pkg::ST_MREAD:
                begin
                    if (margin_stop)
                        state_reg <= cb_writer_pkg::ST_MHOLD;
                end
                cb_writer_pkg::ST_MHOLD:
                begin
                    if (cnt_reg == `CB_CNT_W'(`CB_MARGIN_DISABLE_CYC - 1))
                        state_reg <= cb_writer_pkg::ST_IDLE;
                end
                default:
                    state_reg <= cb_writer_pkg::ST_IDLE;
            endcase
        end
    end

    // delay counter, cleared on every state change
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            cnt_reg <= '0;
        else if (state_reg == cb_writer_pkg::ST_MSETUP || state_reg == cb_writer_pkg::ST_MHOLD
                 || state_reg == cb_writer_pkg::ST_WAIT)
        begin
            if ((state_reg == cb_writer_pkg::ST_MSETUP
                 && cnt_reg == `CB_CNT_W'(`CB_MARGIN_SETUP_CYC - 1))
                || (state_reg == cb_writer_pkg::ST_MHOLD
                 && cnt_reg == `CB_CNT_W'(`CB_MARGIN_DISABLE_CYC - 1))
                || (state_reg == cb_writer_pkg::ST_WAIT && !write_busy && cnt_reg != '0))
                cnt_reg <= '0;
            else if (state_reg != cb_writer_pkg::ST_WAIT || cnt_reg == '0)
                cnt_reg <= cnt_reg + `CB_CNT_W'(1);
        end
        else
            cnt_reg <= '0;
    end

    // address and data walk
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            addr_reg <= '0;
            data_reg <= `CB_PATTERN;
        end
        else if (state_reg == cb_writer_pkg::ST_IDLE && start)
        begin
            addr_reg <= '0;
            data_reg <= invert ? ~`CB_PATTERN : `CB_PATTERN;
        end
        else if (state_reg == cb_writer_pkg::ST_LOAD && !last_col)
            addr_reg <= addr_reg + 13'h1;
        else if (state_reg == cb_writer_pkg::ST_WAIT && !write_busy && cnt_reg != '0
                 && addr_reg != `CB_LAST_ADDR)
        begin
            // carry out of row field steps the bank bits in order 00,01,10,11
            addr_reg <= addr_reg + 13'h1;
            if (last_row)
                data_reg <= inv_reg ? ~`CB_PATTERN : `CB_PATTERN;
            else
                data_reg <= ~data_reg;
        end
    end

    // polarity held for the whole run, so a late invert change cannot split banks
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            inv_reg <= 1'b0;
        end
        else if (state_reg == cb_writer_pkg::ST_IDLE && start)
        begin
            inv_reg <= invert;
        end
    end

    // address and data pins
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            addr <= '0;
            data_out <= '0;
        end
        else
        begin
            addr <= addr_reg;
            data_out <= data_reg;
        end
    end

    // device strobes
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            load_strobe <= 1'b0;
            write_strobe <= 1'b0;
        end
        else
        begin
            load_strobe <= (state_reg == cb_writer_pkg::ST_LOAD);
            write_strobe <= (state_reg == cb_writer_pkg::ST_WRITE);
        end
    end

    // margin pins; voltage idles high
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            chip_select <= 1'b0;
            margin_voltage_pin <= 1'b1;
            margin_enable_pin <= 1'b0;
        end
        else
        begin
            chip_select <= (state_reg == cb_writer_pkg::ST_MREAD);
            margin_voltage_pin <= !(state_reg == cb_writer_pkg::ST_MSETUP
                                    || state_reg == cb_writer_pkg::ST_MREAD
                                    || state_reg == cb_writer_pkg::ST_MHOLD);
            margin_enable_pin <= (state_reg == cb_writer_pkg::ST_MREAD);
        end
    end

    // status; busy lags the state by one cycle
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            busy <= 1'b0;
            done <= 1'b0;
        end
        else
        begin
            busy <= (state_reg != cb_writer_pkg::ST_IDLE);
            done <= (state_reg == cb_writer_pkg::ST_WAIT && !write_busy && cnt_reg != '0
                     && addr_reg == `CB_LAST_ADDR);
        end
    end
endmodule : cb_writer
`default_nettype wire

// [src/cb_writer_defines.svh]
// Purpose: constants for the checkerboard pattern writer (host side)
// Assumes: 50 MHz sys_clk, 8K x 8 byte-wide nonvolatile array
// Notes: timing counts derived from times in microseconds
`ifndef CB_WRITER_DEFINES_SVH
`define CB_WRITER_DEFINES_SVH

`define CB_ADDR_W 13
`define CB_COL_LSB 0
`define CB_ROW_LSB 4
`define CB_BANK_LSB 11
`define CB_LAST_COL 4'hF
`define CB_LAST_ROW 7'h7F
`define CB_LAST_ADDR 13'h1FFF
`define CB_PATTERN 8'h55
`define CB_CLK_MHZ 50
`define CB_MARGIN_SETUP_US 50
`define CB_MARGIN_DISABLE_US 20
`define CB_MARGIN_SETUP_CYC (`CB_MARGIN_SETUP_US * `CB_CLK_MHZ)
`define CB_MARGIN_DISABLE_CYC (`CB_MARGIN_DISABLE_US * `CB_CLK_MHZ)
`define CB_CNT_W 12

`endif

// [src/cb_writer_pkg.sv]
// Purpose: types for the checkerboard pattern writer
// Assumes: one-hot state encoding
// Notes: none
package cb_writer_pkg;
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_LOAD = 7'h02,
        ST_WRITE = 7'h04,
        ST_WAIT = 7'h08,
        ST_MSETUP = 7'h10,
        ST_MREAD = 7'h20,
        ST_MHOLD = 7'h40
    } wr_state_t;
endpackage : cb_writer_pkg

// [testbench/cb_writer_props.sv]
// Purpose: port checker for cb_writer
// Assumes: 50 MHz sys_clk
// Notes: counters time the margin delays
`timescale 1ns/1ns
`default_nettype none
module cb_writer_props (
    // clock
    input wire logic sys_clk,
    input wire logic sys_rst,
    // ports watched
    input wire logic start,
    input wire logic invert,
    input wire logic busy,
    input wire logic [12:0] addr,
    input wire logic [7:0] data_out,
    input wire logic load_strobe,
    input wire logic write_strobe,
    input wire logic write_busy,
    input wire logic chip_select,
    input wire logic margin_voltage_pin,
    input wire logic margin_enable_pin
);
    logic inv_reg;
    logic [12:0] last_reg;
    logic [11:0] set_reg;
    logic [11:0] off_reg;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    always_ff @(posedge sys_clk)
    begin
        if (start && !busy) inv_reg <= invert;
        if (load_strobe) last_reg <= addr;
        set_reg <= margin_voltage_pin ? 12'h000 : set_reg + 12'h001;
        off_reg <= (margin_voltage_pin || margin_enable_pin) ? 12'h000 : off_reg + 12'h001;
    end
    addr_step_a: assert property (load_strobe && addr != 13'h0 |->
        addr == last_reg + 13'h1) else $error("address step");
    data_pat_a: assert property (load_strobe |->
        data_out == ((addr[4] ^ inv_reg) ? 8'hAA : 8'h55)) else $error("data byte");
    row_commit_a: assert property (load_strobe && addr[3:0] == 4'hF |=>
        write_strobe && !load_strobe) else $error("no commit");
    write_pulse_a: assert property (write_strobe |->
        $past(load_strobe) && last_reg[3:0] == 4'hF ##1 !write_strobe) else $error("write");
    wait_done_a: assert property (write_busy |-> !load_strobe) else $error("load early");
    first_load_a: assert property (start && !busy |->
        ##2 load_strobe && addr == 13'h0) else $error("first load");
    margin_set_a: assert property ($rose(chip_select) |->
        set_reg >= 12'h9C4) else $error("setup short");
    margin_off_a: assert property ($rose(margin_voltage_pin) |->
        off_reg >= 12'h3E8) else $error("release short");
endmodule : cb_writer_props
bind cb_writer cb_writer_props chk_i (.*);
`default_nettype wire

// [testbench/eeprom_model.sv]
// Purpose: behavioural byte-wide array
// Assumes: one-cycle write_strobe; load_strobe may stay high, one byte stored per cycle
// Notes: bytes land at load time, simpler than a row latch
`timescale 1ns/1ns
`default_nettype none
module eeprom_model #(parameter int BUSY_CYC = 6) (
    // host side
    input wire logic sys_clk,
    input wire logic [12:0] addr,
    input wire logic [7:0] data_out,
    input wire logic load_strobe,
    input wire logic write_strobe,
    output logic write_busy
);
    logic [7:0] mem [0:8191];
    logic [12:0] last_reg;
    int busy_cnt = 0;
    always @(posedge sys_clk)
    begin
        if (load_strobe) mem[addr] <= data_out;
        if (load_strobe) last_reg <= addr;
        busy_cnt <= write_strobe ? BUSY_CYC : (busy_cnt > 0 ? busy_cnt - 1 : 0);
    end
    assign write_busy = busy_cnt > 0;
endmodule : eeprom_model
`default_nettype wire

// [testbench/testbench.sv]
// Purpose: self-checking bench for cb_writer
// Assumes: inputs change 1 ns after the edge
// Notes: whole array written twice
`timescale 1ns/1ns
`default_nettype none
module testbench;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic start = 1'b0;
    logic invert = 1'b0;
    logic margin_start = 1'b0;
    logic margin_stop = 1'b0;
    logic busy, done, load_strobe, write_strobe, write_busy, chip_select;
    logic margin_voltage_pin, margin_enable_pin;
    logic [12:0] addr;
    logic [7:0] data_out;
    int n_fail = 0;
    int comparisons = 0;
    cb_writer dut (.*);
    eeprom_model mdl (.*);
    initial forever #10 sys_clk = ~sys_clk;
    task automatic chk(input logic [12:0] got, input logic [12:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic end_sim;
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : end_sim
    // bounded poll; n is cycles spent
    task automatic wait_sig(ref logic sig, input logic lvl, input int lim, output int n);
        n = 0;
        while (sig !== lvl)
        begin
            @(posedge sys_clk);
            #1;
            n++;
            if (n > lim)
            begin
                n_fail++;
                end_sim();
            end
        end
    endtask : wait_sig
    task automatic pulse(ref logic sig);
        sig = 1'b1;
        @(posedge sys_clk);
        #1;
        sig = 1'b0;
    endtask : pulse
    task automatic pattern_test(input logic inv);
        int n;
        wait_sig(busy, 1'b0, 10, n);
        invert = inv;
        pulse(start);
        invert = ~inv;
        wait_sig(done, 1'b1, 30000, n);
        for (int a = 0; a < 8192; a++)
            chk(mdl.mem[a], (a[4] ^ inv) ? 13'hAA : 13'h55);
        chk(mdl.last_reg, 13'h1FFF);
        $display("pattern inv=%0d end", inv);
    endtask : pattern_test
    task automatic margin_test;
        int n;
        wait_sig(busy, 1'b0, 10, n);
        pulse(margin_start);
        wait_sig(margin_voltage_pin, 1'b0, 10, n);
        wait_sig(chip_select, 1'b1, 3000, n);
        chk(13'(n >= 2500), 13'h1);
        pulse(margin_stop);
        wait_sig(margin_enable_pin, 1'b0, 10, n);
        wait_sig(margin_voltage_pin, 1'b1, 1500, n);
        chk(13'(n >= 1000), 13'h1);
        $display("margin end");
    endtask : margin_test
    initial
    begin
        repeat (8) @(posedge sys_clk);
        #1;
        sys_rst = 1'b0;
        pattern_test(1'b0);
        pattern_test(1'b1);
        margin_test();
        end_sim();
    end
endmodule : testbench
`default_nettype wire
